// ---- common/sfs_pkg.sv ----
package sfs_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SFS_ADR_STAT = 8'h00;
  localparam logic [7:0] SFS_ADR_CON1 = 8'h04;
  localparam logic [7:0] SFS_ADR_CON2 = 8'h08;
  localparam logic [7:0] SFS_ADR_BUF = 8'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SFS_ST_MODULE_ENABLE = 15;
  localparam int SFS_ST_IDLE_STOP = 13;
  localparam int SFS_ST_RX_OVERFLOW = 6;
  localparam int SFS_ST_TX_FULL = 1;
  localparam int SFS_ST_RX_FULL = 0;
  localparam int SFS_C1_CLOCK_PIN_DISABLE = 12;
  localparam int SFS_C1_DATA_OUT_DISABLE = 11;
  localparam int SFS_C1_WORD_WIDTH_SELECT = 10;
  localparam int SFS_C1_INPUT_SAMPLE_PHASE = 9;
  localparam int SFS_C1_CLOCK_EDGE_SELECT = 8;
  localparam int SFS_C1_SELECT_PIN_ENABLE = 7;
  localparam int SFS_C1_CLOCK_IDLE_POLARITY = 6;
  localparam int SFS_C1_MASTER_SELECT = 5;
  localparam int SFS_C1_SEC_LSB = 2;
  localparam int SFS_C1_PRI_LSB = 0;
  localparam int SFS_C2_FRAMED_MODE_ENABLE = 15;
  localparam int SFS_C2_SYNC_DIRECTION = 14;
  localparam int SFS_C2_SYNC_POLARITY = 13;
  localparam int SFS_C2_SYNC_TIMING = 1;
  localparam int SFS_PIN_SCK = 0;
  localparam int SFS_PIN_SDI = 1;
  localparam int SFS_PIN_SS = 2;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] SFS_STAT_RST = 16'h0000;
  localparam logic [15:0] SFS_CON1_RST = 16'h0000;
  localparam logic [15:0] SFS_CON2_RST = 16'h0000;
  localparam logic [15:0] SFS_STAT_WMASK = 16'ha000;
  localparam logic [15:0] SFS_CON1_WMASK = 16'h1fff;
  localparam logic [15:0] SFS_CON2_WMASK = 16'he002;

  // ----------------------------------------------------------------
  // timing: half-period steps per word and prescaler ratios
  // ----------------------------------------------------------------
  localparam logic [5:0] SFS_TWO_N_8 = 6'h10;
  localparam logic [5:0] SFS_TWO_N_16 = 6'h20;
  localparam logic [3:0] SFS_MSB_8 = 4'h7;
  localparam logic [3:0] SFS_MSB_16 = 4'hf;
  localparam logic [9:0] SFS_PRI_64 = 10'h040;
  localparam logic [9:0] SFS_PRI_16 = 10'h010;
  localparam logic [9:0] SFS_PRI_4 = 10'h004;
  localparam logic [9:0] SFS_PRI_1 = 10'h001;
  localparam logic [9:0] SFS_SEC_BASE = 10'h008;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WAIT = 2'b01,
    ENG_PRE = 2'b10,
    ENG_SHIFT = 2'b11
  } sfs_eng_t;

endpackage : sfs_pkg

// ---- core/sfs_spi.sv ----
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// Function
// - one 16-bit shift register feeds separate transmit and receive buffers
// - master drives the serial clock pin, slave takes it as input
// - module enable hands the four pins to the port; clear switches it off
// - idle-stop bit halts the port while the device is in idle mode
// - word arriving while receive buffer full is discarded and overflow set
// - transmit full sets on buffer write, clears when word enters shifter
// - receive full sets when word reaches buffer, clears on buffer read
// - clock pin disable stops master clock and releases the clock pin
// - data-out disable releases the data-out pin
// - word width select picks 16-bit or 8-bit words
// - master samples input at end or middle of bit; slave keeps it clear
// - clock-edge bit picks which clock transition changes output data; framed mode keeps it clear
// - slave uses active-low select pin only when select enable is set
// - clock polarity bit sets idle level high or low
// - master select bit picks master or slave mode
// - framed mode uses the select pin as frame sync pulse
// - sync direction makes frame sync an input or an output
// - sync polarity makes frame sync active high or active low
// - sync timing puts pulse on first bit or one bit clock before
module sfs_spi
  import sfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output var logic [31:0] WB_DAT_O,
  output var logic WB_ACK_O,
  input wire logic IDLE_MODE,
  input wire logic SCK_I,
  output var logic SCK_O,
  output var logic SCK_OE_N,
  input wire logic SDI_I,
  output var logic SDO_O,
  output var logic SDO_OE_N,
  input wire logic SS_I,
  output var logic SS_O,
  output var logic SS_OE_N
);

  typedef struct packed {
    logic [15:0] stat;
    logic rov;
    logic tbf;
    logic rbf;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] txb;
    logic [15:0] rxb;
    logic [15:0] sr;
    sfs_eng_t eng;
    logic pre;
    logic [5:0] step;
    logic [9:0] cnt;
    logic sck_lvl;
    logic sck_prev;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [31:0] dat_o;
    logic ack;
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
    logic ss_o;
    logic ss_oe_n;
  } sfs_state_t;

  localparam sfs_state_t SFS_RST = '{
    stat: SFS_STAT_RST,
    c1: SFS_CON1_RST,
    c2: SFS_CON2_RST,
    eng: ENG_IDLE,
    sck_oe_n: 1'b1,
    sdo_oe_n: 1'b1,
    ss_oe_n: 1'b1,
    default: '0
  };

  sfs_state_t q;
  sfs_state_t d;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic en, idle_stop, master, w16, smp_eff, cke_eff, select_pin_enable, clock_idle_polarity, clock_pin_disable, data_out_disable;
  logic framed_mode_enable, sfsd, sync_polarity, sync_timing;

  assign en = q.stat[SFS_ST_MODULE_ENABLE];
  assign idle_stop = q.stat[SFS_ST_IDLE_STOP];
  assign master = q.c1[SFS_C1_MASTER_SELECT];
  assign w16 = q.c1[SFS_C1_WORD_WIDTH_SELECT];
  assign smp_eff = q.c1[SFS_C1_INPUT_SAMPLE_PHASE] & master;
  assign framed_mode_enable = q.c2[SFS_C2_FRAMED_MODE_ENABLE];
  assign cke_eff = q.c1[SFS_C1_CLOCK_EDGE_SELECT] & ~framed_mode_enable;
  assign select_pin_enable = q.c1[SFS_C1_SELECT_PIN_ENABLE] & ~framed_mode_enable;
  assign clock_idle_polarity = q.c1[SFS_C1_CLOCK_IDLE_POLARITY];
  assign clock_pin_disable = q.c1[SFS_C1_CLOCK_PIN_DISABLE];
  assign data_out_disable = q.c1[SFS_C1_DATA_OUT_DISABLE];
  assign sfsd = q.c2[SFS_C2_SYNC_DIRECTION];
  assign sync_polarity = q.c2[SFS_C2_SYNC_POLARITY];
  assign sync_timing = q.c2[SFS_C2_SYNC_TIMING];

  // half-period length of the master clock in peripheral clocks
  function automatic logic [9:0] sfs_half_div(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] p;
    logic [9:0] s;
    logic [19:0] prod;
    case (pri)
      2'b00: p = SFS_PRI_64;
      2'b01: p = SFS_PRI_16;
      2'b10: p = SFS_PRI_4;
      default: p = SFS_PRI_1;
    endcase
    s = SFS_SEC_BASE - {7'h00, sec};
    prod = p * s;
    return prod[9:0];
  endfunction : sfs_half_div

  logic bus_req, wr, rd, halt, sck_s, edge_lead, edge_trail, tick, step;
  logic sync_act, selected, run, sample, ochg, done, sync_out;
  logic [15:0] wm;
  logic [15:0] rdat;
  logic [9:0] div;
  logic [5:0] two_n, soff, rel;
  logic [3:0] msb;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    bus_req = WB_CYC_I & WB_STB_I & ~q.ack;
    wr = bus_req & WB_WE_I;
    rd = bus_req & ~WB_WE_I;
    wm = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    halt = idle_stop & IDLE_MODE;
    two_n = w16 ? SFS_TWO_N_16 : SFS_TWO_N_8;
    msb = w16 ? SFS_MSB_16 : SFS_MSB_8;
    div = sfs_half_div(q.c1[SFS_C1_PRI_LSB +: 2], q.c1[SFS_C1_SEC_LSB +: 3]);
    tick = 1'b0;
    run = 1'b0;
    done = 1'b0;
    sample = 1'b0;
    ochg = 1'b0;
    rdat = 16'h0000;

    // pin synchronisers, edges seen on the second stage only
    d.s1 = {SS_I, SDI_I, SCK_I};
    d.s2 = q.s1;
    sck_s = q.s2[SFS_PIN_SCK];
    d.sck_prev = sck_s;
    edge_lead = (sck_s != q.sck_prev) & (sck_s == ~clock_idle_polarity);
    edge_trail = (sck_s != q.sck_prev) & (sck_s == clock_idle_polarity);
    sync_act = q.s2[SFS_PIN_SS] == sync_polarity;
    selected = ~select_pin_enable | ~q.s2[SFS_PIN_SS];

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    d.ack = bus_req;
    case (WB_ADR_I)
      SFS_ADR_STAT:
      begin
        rdat = q.stat;
        rdat[SFS_ST_RX_OVERFLOW] = q.rov;
        rdat[SFS_ST_TX_FULL] = q.tbf;
        rdat[SFS_ST_RX_FULL] = q.rbf;
        if (wr)
        begin
          d.stat = (q.stat & ~(wm & SFS_STAT_WMASK)) | (WB_DAT_I[15:0] & wm & SFS_STAT_WMASK);
          if (WB_SEL_I[0] && !WB_DAT_I[SFS_ST_RX_OVERFLOW])
          begin
            d.rov = 1'b0;
          end
        end
      end
      SFS_ADR_CON1:
      begin
        rdat = q.c1;
        if (wr)
        begin
          d.c1 = (q.c1 & ~(wm & SFS_CON1_WMASK)) | (WB_DAT_I[15:0] & wm & SFS_CON1_WMASK);
        end
      end
      SFS_ADR_CON2:
      begin
        rdat = q.c2;
        if (wr)
        begin
          d.c2 = (q.c2 & ~(wm & SFS_CON2_WMASK)) | (WB_DAT_I[15:0] & wm & SFS_CON2_WMASK);
        end
      end
      SFS_ADR_BUF:
      begin
        rdat = q.rxb;
        if (rd)
        begin
          d.rbf = 1'b0;
        end
      end
      default:
      begin
        rdat = 16'h0000;
      end
    endcase
    if (rd)
    begin
      d.dat_o = {16'h0000, rdat};
    end

    // ----------------------------------------------------------------
    // clock generation and step events
    // ----------------------------------------------------------------
    if (master && !clock_pin_disable && !halt && (q.eng == ENG_PRE || q.eng == ENG_SHIFT))
    begin
      if (q.cnt == div - 10'h001)
      begin
        d.cnt = 10'h000;
        tick = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + 10'h001;
      end
    end
    else
    begin
      d.cnt = 10'h000;
    end
    step = master ? tick : ((edge_lead | edge_trail) & ~halt);

    // sample and output-change positions within the word
    soff = {5'h00, ~cke_eff} + {5'h00, smp_eff};
    rel = q.step - soff;
    sample = (q.step >= soff) && !rel[0] && (rel < two_n);
    if (cke_eff)
    begin
      ochg = q.step[0] && (q.step < two_n - 6'h01);
    end
    else
    begin
      ochg = !q.step[0] && (q.step != 6'h00) && (q.step < two_n - 6'h01);
    end

    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    case (q.eng)
      ENG_IDLE:
      begin
        d.step = 6'h00;
        d.pre = 1'b0;
        d.sck_lvl = clock_idle_polarity;
        if (!halt && ((master && q.tbf) || (!master && (framed_mode_enable || selected))))
        begin
          if (q.tbf)
          begin
            d.sr = q.txb;
            d.tbf = 1'b0;
            d.sdo_o = q.txb[msb];
          end
          else
          begin
            d.sdo_o = q.sr[msb];
          end
          if (framed_mode_enable && (sfsd || !master))
          begin
            d.eng = ENG_WAIT;
          end
          else if (framed_mode_enable && !sync_timing)
          begin
            d.eng = ENG_PRE;
          end
          else
          begin
            d.eng = ENG_SHIFT;
          end
        end
      end
      ENG_WAIT:
      begin
        if (master && sync_act)
        begin
          d.eng = sync_timing ? ENG_SHIFT : ENG_PRE;
        end
        else if (!master && edge_lead && sync_act && !halt)
        begin
          // slave clock: with late sync this edge is already bit zero
          d.eng = sync_timing ? ENG_SHIFT : ENG_PRE;
          d.pre = 1'b1;
          run = sync_timing;
        end
      end
      ENG_PRE:
      begin
        if (step)
        begin
          d.pre = ~q.pre;
          if (master)
          begin
            d.sck_lvl = ~q.sck_lvl;
          end
          if (q.pre)
          begin
            d.eng = ENG_SHIFT;
          end
        end
      end
      ENG_SHIFT:
      begin
        run = step;
        if (!master && !selected)
        begin
          d.eng = ENG_IDLE;
          run = 1'b0;
        end
      end
      default:
      begin
        d.eng = ENG_IDLE;
      end
    endcase

    if (run)
    begin
      if (sample)
      begin
        d.sr = {q.sr[14:0], q.s2[SFS_PIN_SDI]};
      end
      if (ochg)
      begin
        d.sdo_o = sample ? q.sr[msb - 4'h1] : q.sr[msb];
      end
      if (master && q.step < two_n)
      begin
        d.sck_lvl = ~q.sck_lvl;
      end
      d.step = q.step + 6'h01;
      done = master ? (q.step == two_n) : (q.step == two_n - 6'h01);
    end

    if (done)
    begin
      d.eng = ENG_IDLE;
      if (d.rbf)
      begin
        d.rov = 1'b1;
      end
      else
      begin
        d.rxb = w16 ? d.sr : {8'h00, d.sr[7:0]};
        d.rbf = 1'b1;
      end
    end

    // buffer write after the engine so a write beside a load keeps the flag
    if (wr && WB_ADR_I == SFS_ADR_BUF)
    begin
      d.txb = (q.txb & ~wm) | (WB_DAT_I[15:0] & wm);
      d.tbf = 1'b1;
    end

    if (!en)
    begin
      d.eng = ENG_IDLE;
      d.step = 6'h00;
      d.pre = 1'b0;
      d.sck_lvl = clock_idle_polarity;
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    sync_out = (d.eng == ENG_PRE) || (d.eng == ENG_SHIFT && sync_timing && d.step < 6'h02);
    d.ss_o = sync_out ? sync_polarity : ~sync_polarity;
    d.ss_oe_n = ~(en & framed_mode_enable & ~sfsd);
    d.sck_o = d.sck_lvl;
    d.sck_oe_n = ~(en & master & ~clock_pin_disable);
    d.sdo_oe_n = ~(en & ~data_out_disable);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      q <= SFS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign WB_DAT_O = q.dat_o;
  assign WB_ACK_O = q.ack;
  assign SCK_O = q.sck_o;
  assign SCK_OE_N = q.sck_oe_n;
  assign SDO_O = q.sdo_o;
  assign SDO_OE_N = q.sdo_oe_n;
  assign SS_O = q.ss_o;
  assign SS_OE_N = q.ss_oe_n;

endmodule : sfs_spi

`default_nettype wire

// ---- dv/sfs_spi_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// bus and pin checks
// ---------------------------------------------
module sfs_spi_chk
  import sfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic IDLE_MODE,
  input wire logic SCK_O,
  input wire logic SCK_OE_N,
  input wire logic SDO_O,
  input wire logic SDO_OE_N,
  input wire logic SS_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [15:0] st_q, c1_q, c2_q, m;
  logic tk, en, mst;
  assign tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign m = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign en = st_q[SFS_ST_MODULE_ENABLE];
  assign mst = c1_q[SFS_C1_MASTER_SELECT];
  // shadow of the control bits, updated at the taking edge
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q <= 16'h0000;
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
    end
    else if (tk && WB_WE_I)
    begin
      if (WB_ADR_I == SFS_ADR_STAT) st_q <= (st_q & ~m) | (WB_DAT_I[15:0] & m);
      if (WB_ADR_I == SFS_ADR_CON1) c1_q <= (c1_q & ~m) | (WB_DAT_I[15:0] & m);
      if (WB_ADR_I == SFS_ADR_CON2) c2_q <= (c2_q & ~m) | (WB_DAT_I[15:0] & m);
    end
  end
  property p_oe(logic oe_n, logic want);
    $stable({st_q, c1_q, c2_q}) |-> oe_n == !want;
  endproperty
  a_ack_answer: assert property (tk |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_rdata_hold: assert property (!(tk && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data moved");
  a_sck_drive: assert property (p_oe(SCK_OE_N, en && mst && !c1_q[SFS_C1_CLOCK_PIN_DISABLE]))
    else $error("clock pin drive wrong");
  a_sdo_drive: assert property (p_oe(SDO_OE_N, en && !c1_q[SFS_C1_DATA_OUT_DISABLE]))
    else $error("data pin drive wrong");
  a_sync_drive: assert property (p_oe(SS_OE_N, en && c2_q[SFS_C2_FRAMED_MODE_ENABLE] && !c2_q[SFS_C2_SYNC_DIRECTION]))
    else $error("sync pin drive wrong");
  a_clk_stopped: assert property (en && mst && c1_q[SFS_C1_CLOCK_PIN_DISABLE] && $stable(c1_q) |=> $stable(SCK_O))
    else $error("clock runs while disabled");
  a_idle_freeze: assert property (en && st_q[SFS_ST_IDLE_STOP] && IDLE_MODE && $stable(st_q) |=> $stable(SCK_O) && $stable(SDO_O))
    else $error("port runs in idle");
  c_read: cover property (tk && !WB_WE_I ##1 WB_ACK_O);
  c_master: cover property (en && mst && !SCK_OE_N && $changed(SCK_O));
  c_idle: cover property (en && st_q[SFS_ST_IDLE_STOP] && IDLE_MODE);
  c_sync: cover property (!SS_OE_N);
endmodule : sfs_spi_chk
bind sfs_spi sfs_spi_chk i_chk (.CLK, .RSTN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_DAT_O, .WB_ACK_O, .IDLE_MODE, .SCK_O, .SCK_OE_N, .SDO_O, .SDO_OE_N, .SS_OE_N);
`default_nettype wire

// ---- dv/sfs_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// far-side serial partner
// ---------------------------------------------
module sfs_peer
(
  input wire logic sck_in,
  input wire logic sdo,
  output var logic sck_gen,
  output wire logic sdi,
  output var logic ss_n,
  output var logic [15:0] rx
);
  logic [15:0] sh;
  initial
  begin
    sck_gen = 1'b0;
    ss_n = 1'b1;
    sh = 16'h0000;
    rx = 16'h0000;
  end
  assign sdi = sh[15];
  always @(posedge sck_in) rx <= {rx[14:0], sdo};
  // refill with inverted bits so a stale level never looks valid
  always @(negedge sck_in) sh <= {sh[14:0], ~sh[0]};
  task automatic load(input logic [15:0] v);
    sh = v;
    rx = 16'h0000;
  endtask : load
  // clock stands low outside frames, 800 ns period inside
  task automatic run(input int n);
    #37 ss_n = 1'b0;
    repeat (n)
    begin
      #400 sck_gen = 1'b1;
      #400 sck_gen = 1'b0;
    end
    #400 ss_n = 1'b1;
  endtask : run
endmodule : sfs_peer
`default_nettype wire

// ---- dv/sfs_spi_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfs_spi_tb
  import sfs_pkg::*;
;
  logic clk, rstn, cyc, stb, we, idle, ack, sck_o, sck_oe_n, sdo_o, sdo_oe_n, ss_oe_n;
  logic p_sck, p_sdi, p_ss_n, ss_o;
  logic [3:0] lanes = 4'h3;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] p_rx;
  int errors = 0;
  int cmp_count = 0;
  wire logic sck_w = sck_oe_n ? p_sck : sck_o;
  wire logic sdo_w = sdo_oe_n ? 1'b1 : sdo_o;
  sfs_spi i_dut (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IDLE_MODE(idle), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .SDI_I(p_sdi), .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .SS_I(p_ss_n),
    .SS_O(ss_o), .SS_OE_N(ss_oe_n));
  sfs_peer i_peer (.sck_in(sck_w), .sdo(sdo_w), .sck_gen(p_sck), .sdi(p_sdi), .ss_n(p_ss_n), .rx(p_rx));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic tmo();
    errors++;
    complete_run();
  endtask : tmo
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[15:0];
    if (n >= 50) tmo();
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rdc
  task automatic wait_bit(input int b);
    logic [15:0] q;
    int n = 0;
    do
    begin
      wb(1'b0, SFS_ADR_STAT, 16'h0000, q);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (n >= 300) tmo();
  endtask : wait_bit
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    rdc(SFS_ADR_STAT, 16'h0000);
    rdc(SFS_ADR_CON1, 16'h0000);
    rdc(SFS_ADR_CON2, 16'h0000);
    rdc(8'h10, 16'h0000);
    wr(SFS_ADR_CON1, 16'hfffb);
    rdc(SFS_ADR_CON1, 16'h1ffb);
    wr(SFS_ADR_STAT, 16'hffff);
    rdc(SFS_ADR_STAT, 16'ha000);
    chk(16'(sck_oe_n), 16'h0001);
    chk(16'(sdo_oe_n), 16'h0001);
    wr(SFS_ADR_CON1, 16'h0000);
    lanes = 4'h2;
    wr(SFS_ADR_CON1, 16'hffff);
    lanes = 4'h3;
    rdc(SFS_ADR_CON1, 16'h1f00);
    wr(SFS_ADR_CON1, 16'h0000);
    wr(SFS_ADR_CON2, 16'hffff);
    rdc(SFS_ADR_CON2, 16'he002);
    chk(16'(ss_oe_n), 16'h0001);
    wr(SFS_ADR_CON2, 16'h8000);
    chk(16'(ss_oe_n), 16'h0000);
    chk(16'(ss_o), 16'h0001);
    wr(SFS_ADR_CON2, 16'h0000);
    wr(SFS_ADR_STAT, 16'h0000);
    chk(16'(sdo_oe_n), 16'h0001);
    $display("test regs done");
  endtask : t_regs
  task automatic t_master();
    // half period of four clocks leaves room for the input synchronisers
    wr(SFS_ADR_CON1, 16'h0133);
    wr(SFS_ADR_STAT, 16'h8000);
    i_peer.load(16'ha500);
    wr(SFS_ADR_BUF, 16'h003c);
    wait_bit(0);
    chk(p_rx, 16'h003c);
    i_peer.load(16'h6600);
    wr(SFS_ADR_BUF, 16'h0081);
    wait_bit(6);
    rdc(SFS_ADR_STAT, 16'h8041);
    rdc(SFS_ADR_BUF, 16'h00a5);
    rdc(SFS_ADR_STAT, 16'h8040);
    wr(SFS_ADR_STAT, 16'h8000);
    rdc(SFS_ADR_STAT, 16'h8000);
    $display("test master done");
  endtask : t_master
  task automatic t_wide();
    wr(SFS_ADR_CON1, 16'h0533);
    i_peer.load(16'h1234);
    wr(SFS_ADR_BUF, 16'hbeef);
    wait_bit(0);
    chk(p_rx, 16'hbeef);
    rdc(SFS_ADR_BUF, 16'h1234);
    $display("test wide done");
  endtask : t_wide
  task automatic t_idle();
    wr(SFS_ADR_CON1, 16'h0133);
    wr(SFS_ADR_STAT, 16'ha000);
    i_peer.load(16'h7700);
    idle <= 1'b1;
    wr(SFS_ADR_BUF, 16'h0011);
    repeat (60) @(posedge clk);
    rdc(SFS_ADR_STAT, 16'ha002);
    idle <= 1'b0;
    wait_bit(0);
    rdc(SFS_ADR_STAT, 16'ha001);
    rdc(SFS_ADR_BUF, 16'h0077);
    chk(p_rx, 16'h0011);
    wr(SFS_ADR_STAT, 16'h0000);
    $display("test idle done");
  endtask : t_idle
  task automatic t_slave();
    wr(SFS_ADR_CON1, 16'h0180);
    wr(SFS_ADR_STAT, 16'h8000);
    i_peer.load(16'h5a00);
    i_peer.run(8);
    @(posedge clk);
    wait_bit(0);
    rdc(SFS_ADR_BUF, 16'h005a);
    $display("test slave done");
  endtask : t_slave
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rstn = 1'b0;
    {cyc, stb, we, idle} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_master();
    t_wide();
    t_idle();
    t_slave();
    complete_run();
  end
endmodule : sfs_spi_tb
`default_nettype wire
